// ### hdl/trim_fuse_access_control.sv
// Function
// - Trim block holds 7-bit oscillator trim and 3-bit regulator trim.
// - Operation code returns to zero once its operation completes.
// - Code zero: fuses latched into trim block at power-up; a write stores the fields only.
// - Code one: reload trim block from fuses, then copy it to fields.
// - Code two: copy trim block to fields, trim block unchanged.
// - Code three: write fields into trim block, then copy it back.
`include "trim_params.svh"
`default_nettype none

module trim_fuse_access_control
  import trim_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register access
  input wire reg_req_t req_i,
  output var reg_rsp_t rsp_o,
  // Fuse array and trim targets
  input wire trim_t fuse_i,
  output var trim_t trim_o,
  output logic busy_o
);

  seq_state_t state_q, state_d;
  trim_op_t op_q, op_d;
  trim_t fld_q, fld_d;
  trim_t blk_q, blk_d;
  reg_rsp_t rsp_q, rsp_d;
  logic hit;
  logic wr_hit;
  logic rd_hit;
  trim_op_t wr_op;
  trim_t wr_fld;
  logic [15:0] ctrl_view;

  assign hit = (req_i.addr == `TRIM_CTRL_OFFSET);
  assign wr_hit = req_i.wr && hit;
  assign rd_hit = req_i.rd && hit;
  // Write data split into code and fields
  assign wr_op = trim_op_t'(req_i.wdata[`TRIM_OP_MSB:`TRIM_OP_LSB]);
  assign wr_fld.osc = req_i.wdata[`OSC_TRIM_MSB:`OSC_TRIM_LSB];
  assign wr_fld.vreg = req_i.wdata[`TRIM_VREG_MSB:`TRIM_VREG_LSB];

  // Reserved bits always read zero whatever was written
  always_comb begin
    ctrl_view = `TRIM_CTRL_RESET;
    ctrl_view[`TRIM_OP_MSB:`TRIM_OP_LSB] = op_q;
    ctrl_view[`TRIM_RSVD_MSB:`TRIM_RSVD_LSB] = `TRIM_RSVD_READ;
    ctrl_view[`OSC_TRIM_MSB:`OSC_TRIM_LSB] = fld_q.osc;
    ctrl_view[`TRIM_VREG_MSB:`TRIM_VREG_LSB] = fld_q.vreg;
  end

  // Sequencer; the operation code reads back nonzero while an operation runs
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    fld_d = fld_q;
    blk_d = blk_q;
    unique case (state_q)
      ST_PWRUP: begin
        blk_d = fuse_i;
        state_d = ST_IDLE;
      end
      ST_IDLE: begin
        // Writes while busy are dropped so a running copy cannot be torn
        if (wr_hit) begin
          fld_d = wr_fld;
          op_d = wr_op;
          unique case (wr_op)
            OP_NONE: state_d = ST_IDLE;
            OP_RELOAD: state_d = ST_FUSE;
            OP_READBACK: state_d = ST_COPY;
            OP_WRITE: state_d = ST_WRITE;
          endcase
        end
      end
      ST_FUSE: begin
        blk_d = fuse_i;
        state_d = ST_COPY;
      end
      ST_WRITE: begin
        blk_d = fld_q;
        state_d = ST_COPY;
      end
      ST_COPY: begin
        fld_d = blk_q;
        op_d = OP_NONE;
        state_d = ST_IDLE;
      end
      default: begin
        op_d = OP_NONE;
        state_d = ST_IDLE;
      end
    endcase
  end

  // Read port: one-cycle acknowledge, unmapped reads return zero
  always_comb begin
    rsp_d.ack = req_i.rd;
    rsp_d.rdata = rsp_q.rdata;
    if (req_i.rd) begin
      rsp_d.rdata = rd_hit ? ctrl_view : 16'h0000;
    end
  end

  // Sequencer state; the trim block clears on reset and reloads from fuses one cycle later
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_PWRUP;
      op_q <= OP_NONE;
      fld_q <= {`OSC_TRIM_RESET, `TRIM_VREG_RESET};
      blk_q <= {`OSC_TRIM_RESET, `TRIM_VREG_RESET};
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      fld_q <= fld_d;
      blk_q <= blk_d;
    end
  end

  // Read response registers
  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign trim_o = blk_q;
  assign rsp_o = rsp_q;
  // Busy spans load and copy only; the long software wait before reading is not enforced here
  assign busy_o = (state_q != ST_IDLE);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_pwrup_fuse_latch: assert property ((state_q == ST_PWRUP) |=> (trim_o == $past(fuse_i)))
    else $error("trim block not loaded from fuses at power-up");

  a_op_self_clear: assert property ((state_q == ST_COPY) |=> (op_q == OP_NONE) && !busy_o)
    else $error("operation code not cleared after operation");

  a_idle_op_zero: assert property ((state_q == ST_IDLE) |-> (op_q == OP_NONE))
    else $error("operation code nonzero while idle");

  a_reload_path: assert property ((state_q == ST_IDLE) && wr_hit && (wr_op == OP_RELOAD)
      |=> (trim_o == $past(trim_o)) ##1 (trim_o == $past(fuse_i)) ##1 (fld_q == trim_o))
    else $error("reload from fuses not reflected in fields");

  a_readback_keep: assert property ((state_q == ST_IDLE) && wr_hit && (wr_op == OP_READBACK)
      |=> $stable(trim_o) ##1 (fld_q == trim_o) && $stable(trim_o))
    else $error("readback changed trim block or fields wrong");

  a_write_path: assert property ((state_q == ST_IDLE) && wr_hit && (wr_op == OP_WRITE)
      |-> ##2 (trim_o == $past(wr_fld, 2)) ##1 (fld_q == trim_o))
    else $error("written trim values not in trim block");

  a_blk_source: assert property ($changed(trim_o)
      |-> ($past(state_q) inside {ST_PWRUP, ST_FUSE, ST_WRITE}))
    else $error("trim block changed outside a load");

  a_read_layout: assert property (rd_hit |=> rsp_o.ack && (rsp_o.rdata[13:10] == 4'h0)
      && (rsp_o.rdata[9:3] == $past(fld_q.osc)) && (rsp_o.rdata[2:0] == $past(fld_q.vreg)))
    else $error("trim_control read layout wrong");

  // Checks below cover the power-up latch, code zero, busy and completion timing, and field holds and copies
  // Power-up latch runs after every reset, so the block is busy on the first free edge
  a_reset_pwrup: assert property ($fell(rst) |-> (state_q == ST_PWRUP) && busy_o)
    else $error("no power-up latch after reset");

  a_op0_store: assert property ((state_q == ST_IDLE) && wr_hit && (wr_op == OP_NONE)
      |=> $stable(trim_o) && (fld_q == $past(wr_fld)) && !busy_o)
    else $error("code zero write touched trim block");

  a_idle_blk_hold: assert property ((state_q == ST_IDLE) |=> $stable(trim_o))
    else $error("trim block changed while idle");

  a_op_goes_busy: assert property ((state_q == ST_IDLE) && wr_hit && (wr_op != OP_NONE)
      |=> busy_o && (op_q == $past(wr_op)))
    else $error("operation code not held while busy");

  a_op_finishes: assert property ((state_q == ST_IDLE) && wr_hit && (wr_op != OP_NONE)
      |-> ##[2:3] ((state_q == ST_IDLE) && (op_q == OP_NONE)))
    else $error("operation did not complete in time");

  // Fields must not move while the trim block loads; software may still read them
  a_load_fields_hold: assert property ((state_q inside {ST_FUSE, ST_WRITE}) |=> $stable(fld_q))
    else $error("fields changed during a trim block load");

  a_copy_fields: assert property ((state_q == ST_COPY) |=> (fld_q == $past(trim_o)))
    else $error("fields not copied from trim block");

  // Register write and read path checks
  a_write_fields: assert property ((state_q == ST_IDLE) && wr_hit |=> (fld_q == $past(wr_fld)))
    else $error("written fields not stored");

  a_op_bits_read: assert property (rd_hit |=> (rsp_o.rdata[`TRIM_OP_MSB:`TRIM_OP_LSB] == $past(op_q)))
    else $error("operation code bits read back wrong");

  a_unmapped_zero: assert property (req_i.rd && !hit |=> (rsp_o.rdata == 16'h0000))
    else $error("unmapped read not zero");

  a_ack_source: assert property (rsp_o.ack == $past(req_i.rd))
    else $error("acknowledge not one cycle after read");

  // Scenario covers
  c_reload: cover property ((state_q == ST_FUSE) ##1 (state_q == ST_COPY));
  c_readback: cover property ((state_q == ST_IDLE) && wr_hit && (wr_op == OP_READBACK));
  c_write: cover property ((state_q == ST_WRITE) ##1 (state_q == ST_COPY) ##1 (state_q == ST_IDLE));
  c_busy_read: cover property (rd_hit && busy_o);
  c_op_none: cover property ((state_q == ST_IDLE) && wr_hit && (wr_op == OP_NONE));

endmodule : trim_fuse_access_control

`default_nettype wire

// ### pkg/trim_params.svh
`ifndef TRIM_PARAMS_SVH
`define TRIM_PARAMS_SVH

// Register location on the device register map
`define TRIM_CTRL_OFFSET 8'h0A
`define TRIM_CTRL_RESET 16'h0000

// Field positions inside trim_control
`define TRIM_OP_MSB 15
`define TRIM_OP_LSB 14
`define TRIM_RSVD_MSB 13
`define TRIM_RSVD_LSB 10
`define OSC_TRIM_MSB 9
`define OSC_TRIM_LSB 3
`define TRIM_VREG_MSB 2
`define TRIM_VREG_LSB 0

// Field reset values
`define TRIM_OP_RESET 2'h0
`define OSC_TRIM_RESET 7'h00
`define TRIM_VREG_RESET 3'h0
`define TRIM_RSVD_READ 4'h0

`endif

// ### pkg/trim_pkg.sv
`default_nettype none

package trim_pkg;

  typedef enum logic [1:0] {
    OP_NONE     = 2'h0,
    OP_RELOAD   = 2'h1,
    OP_READBACK = 2'h2,
    OP_WRITE    = 2'h3
  } trim_op_t;

  // Oscillator frequency trim and 1.8 V regulator trim
  typedef struct packed {
    logic [6:0] osc;
    logic [2:0] vreg;
  } trim_t;

  // Register access as delivered by the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } reg_rsp_t;

  typedef enum logic [4:0] {
    ST_PWRUP = 5'b00001,
    ST_IDLE  = 5'b00010,
    ST_FUSE  = 5'b00100,
    ST_WRITE = 5'b01000,
    ST_COPY  = 5'b10000
  } seq_state_t;

endpackage : trim_pkg

`default_nettype wire

// ### testbench/trim_fuse_access_control_tb.sv
`default_nettype none

module trim_fuse_access_control_tb
  import trim_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  reg_req_t req_i = '0;
  reg_rsp_t rsp_o;
  trim_t fuse_i = '0;
  trim_t trim_o;
  trim_t t;
  logic busy_o;
  int failures = 0;
  int check_count = 0;
  logic [15:0] exp_q[$];

  initial forever #12.5 clk = ~clk;

  trim_fuse_access_control dut_u (
    .clk(clk),
    .rst(rst),
    .req_i(req_i),
    .rsp_o(rsp_o),
    .fuse_i(fuse_i),
    .trim_o(trim_o),
    .busy_o(busy_o)
  );

  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Bounded wait so a stuck sequencer shows up as a mismatch
  task automatic idle();
    for (int i = 0; i < 8 && busy_o !== 1'b0; i++) @(negedge clk);
    chk("busy", {15'h0, busy_o}, 16'h0000);
  endtask

  task automatic wr(logic [15:0] d, bit w = 1'b1);
    @(negedge clk);
    req_i.wr = 1'b1;
    req_i.addr = 8'h0A;
    req_i.wdata = d;
    @(negedge clk);
    req_i.wr = 1'b0;
    if (w) idle();
  endtask

  task automatic rd(logic [7:0] a, logic [15:0] e);
    @(negedge clk);
    req_i.rd = 1'b1;
    req_i.addr = a;
    exp_q.push_back(e);
    @(negedge clk);
    req_i.rd = 1'b0;
  endtask

  // Scoreboard: oldest noted read against each acknowledged answer
  always @(negedge clk) begin
    if (rsp_o.ack === 1'b1) begin
      if (exp_q.size() > 0)
        chk("rdata", rsp_o.rdata, exp_q.pop_front());
      else
        chk("ack", 16'h0001, 16'h0000);
    end
  end

  initial begin
    void'($urandom(32'h64638CD1));
    fuse_i = trim_t'($urandom);
    repeat (12) @(negedge clk);
    rst = 1'b0;
    idle();
    chk("pwrup", {6'h00, trim_o}, {6'h00, fuse_i});
    rd(8'h0A, 16'h0000);
    t = trim_t'($urandom);
    wr({2'h3, 4'hF, t});
    chk("op3", {6'h00, trim_o}, {6'h00, t});
    rd(8'h0A, {6'h00, t});
    fuse_i = trim_t'($urandom);
    wr({2'h2, 14'h0000});
    chk("op2", {6'h00, trim_o}, {6'h00, t});
    rd(8'h0A, {6'h00, t});
    wr({2'h1, 14'h0000});
    chk("op1", {6'h00, trim_o}, {6'h00, fuse_i});
    rd(8'h0A, {6'h00, fuse_i});
    wr({2'h1, 4'h0, t}, 1'b0);
    rd(8'h0A, {2'h1, 4'h0, t});
    idle();
    chk("op1b", {6'h00, trim_o}, {6'h00, fuse_i});
    t = trim_t'($urandom);
    wr({2'h0, 4'h0, t});
    chk("op0", {6'h00, trim_o}, {6'h00, fuse_i});
    rd(8'h0A, {6'h00, t});
    rd(8'h0B, 16'h0000);
    repeat (3) @(negedge clk);
    chk("left", 16'(exp_q.size()), 16'h0000);
    complete_run();
  end

  initial begin
    #(1000 * 25);
    failures++;
    complete_run();
  end
endmodule // trim_fuse_access_control_tb

`default_nettype wire
